// File: src/two_wire_port.sv
// Two-wire port: target channel logic and the initiator instance
// How it works
// - Target answers write address 0x76 and read address 0x77 after reset.
// - Controller changes the target address by writing register 0x4006.
// - Idle bus: both lines left high by every party.
// - Start is data falling with clock high; stop is data rising.
// - Eight-bit words; target drives low acknowledge, nine clocks per word.
// - Initiator has its own clock and data pins.
// - Initiator writes address, index, data; checks acks; at most five data bytes.
// - Random read uses dummy index write; setting picks stop or repeated start.
// - Initiator reads at most two bytes per transfer.
// - Index increments after each byte; host sets index by dummy write.
// - Target has its own pins and reaches only system registers.
// - Target accepts a transfer only when the bus address matches.
// - Program bytes go one at a time; controller held in reset meanwhile.
// - Sequential read returns successive indexes with no byte limit.
`timescale 1ns/10ps
module two_wire_port (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic sclSIn,
    input wire logic sdaSIn,
    output logic sdaSOut,
    output logic sdaSOe,
    output logic [15:0] regAddr,
    output logic regWrEn,
    output logic [7:0] regWrData,
    output logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic mcuWrEn,
    input wire logic [15:0] mcuAddr,
    input wire logic [7:0] mcuWrData,
    output logic [6:0] tgtDevAddr,
    output logic codeWrEn,
    output logic [15:0] codeWrAddr,
    output logic [7:0] codeWrData,
    output logic mcuHoldReset,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic cmdRead,
    input wire logic cmdRestart,
    input wire logic [6:0] cmdDev,
    input wire logic [7:0] cmdIndex,
    input wire logic [2:0] cmdLen,
    input wire logic [39:0] cmdData,
    output logic donePulse,
    output logic ackErr,
    output logic [15:0] rdData,
    input wire logic sclMIn,
    output logic sclMOut,
    output logic sclMOe,
    input wire logic sdaMIn,
    output logic sdaMOut,
    output logic sdaMOe
);
    two_wire_pkg::tgt_state_t st_q, st_d;
    logic [2:0] bitCnt_q, bitCnt_d;
    logic [1:0] byteNum_q, byteNum_d;
    logic [7:0] sh_q, sh_d, wrData_q, wrData_d;
    logic [15:0] index_q, index_d, codeAddr_q, codeAddr_d;
    logic [6:0] devAddr_q, devAddr_d;
    logic rdMode_q, rdMode_d, oe_q, oe_d, hold_q, hold_d, inc_q, inc_d;
    logic wrEn_q, wrEn_d, rdEn_q, rdEn_d, codeEn_q, codeEn_d;
    logic sclS1_q, sclS2_q, sclS3_q, sdaS1_q, sdaS2_q, sdaS3_q;
    logic sclRise, sclFall, startDet, stopDet;

    // Only the system register page is reachable from the target pins
    function automatic logic inSys(input logic [15:0] idx);
        inSys = (idx[15:8] == two_wire_pkg::SYS_PAGE);
    endfunction

    // Edge and condition detection on the second and third sync stages
    assign sclRise = sclS2_q & ~sclS3_q;
    assign sclFall = ~sclS2_q & sclS3_q;
    assign startDet = sclS2_q & sclS3_q & sdaS3_q & ~sdaS2_q;
    assign stopDet = sclS2_q & sclS3_q & ~sdaS3_q & sdaS2_q;

    // Open drain data pin; clock is input only on this channel
    assign sdaSOut = 1'b0;
    assign sdaSOe = oe_q;
    assign regAddr = index_q;
    assign regWrEn = wrEn_q;
    assign regWrData = wrData_q;
    assign regRdEn = rdEn_q;
    assign tgtDevAddr = devAddr_q;
    assign codeWrEn = codeEn_q;
    assign codeWrAddr = codeAddr_q;
    assign codeWrData = wrData_q;
    assign mcuHoldReset = hold_q;

    // Target channel next state
    always_comb begin
        st_d = st_q; bitCnt_d = bitCnt_q; byteNum_d = byteNum_q; sh_d = sh_q;
        wrData_d = wrData_q; index_d = index_q; codeAddr_d = codeAddr_q;
        devAddr_d = devAddr_q; rdMode_d = rdMode_q; oe_d = oe_q; hold_d = hold_q;
        inc_d = 1'b0; wrEn_d = 1'b0; rdEn_d = 1'b0; codeEn_d = 1'b0;
        // Controller write to the address register
        if (mcuWrEn && mcuAddr == two_wire_pkg::DEV_ADDR_REG) devAddr_d = mcuWrData[7:1];
        // Index steps after the byte has been used, so strobes see it stable
        if (inc_q) index_d = index_q + 16'h0001;
        if (codeEn_q) codeAddr_d = codeAddr_q + 16'h0001;
        if (stopDet) begin
            st_d = two_wire_pkg::T_IDLE; oe_d = 1'b0; hold_d = 1'b0;
        end else if (startDet) begin
            // Repeated start lands here too
            st_d = two_wire_pkg::T_RX; bitCnt_d = 3'h0; byteNum_d = 2'h0; oe_d = 1'b0;
        end else begin
            case (st_q)
                two_wire_pkg::T_IDLE: oe_d = 1'b0;
                two_wire_pkg::T_RX: if (sclRise) begin
                    sh_d = {sh_q[6:0], sdaS2_q};
                    bitCnt_d = bitCnt_q + 3'h1;
                    if (bitCnt_q == 3'h7) st_d = two_wire_pkg::T_DEC;
                end
                two_wire_pkg::T_DEC: if (sclFall) begin
                    st_d = two_wire_pkg::T_ACK;
                    oe_d = 1'b1;
                    byteNum_d = (byteNum_q == 2'h3) ? 2'h3 : byteNum_q + 2'h1;
                    case (byteNum_q)
                        2'h0: begin
                            // Silent unless the address is ours
                            rdMode_d = sh_q[0];
                            if (sh_q[7:1] != devAddr_q) begin
                                st_d = two_wire_pkg::T_IDLE; oe_d = 1'b0;
                            end
                        end
                        2'h1: index_d[15:8] = sh_q;
                        2'h2: index_d[7:0] = sh_q;
                        default: begin
                            wrData_d = sh_q; inc_d = 1'b1;
                            wrEn_d = inSys(index_q);
                            // Download path into code memory
                            if (index_q == two_wire_pkg::CODE_ADDR_HI_REG) begin
                                codeAddr_d[15:8] = sh_q; hold_d = 1'b1;
                            end
                            if (index_q == two_wire_pkg::CODE_ADDR_LO_REG) begin
                                codeAddr_d[7:0] = sh_q; hold_d = 1'b1;
                            end
                            if (index_q == two_wire_pkg::CODE_DATA_REG) begin
                                codeEn_d = 1'b1; hold_d = 1'b1;
                            end
                        end
                    endcase
                end
                two_wire_pkg::T_ACK: if (sclFall) begin
                    oe_d = 1'b0; bitCnt_d = 3'h0;
                    st_d = two_wire_pkg::T_RX;
                    if (rdMode_q) begin
                        // Load next byte; no count limit on reads
                        sh_d = inSys(index_q) ? regRdData : 8'h00;
                        oe_d = inSys(index_q) ? ~regRdData[7] : 1'b1;
                        rdEn_d = inSys(index_q);
                        inc_d = 1'b1;
                        st_d = two_wire_pkg::T_TX;
                    end
                end
                two_wire_pkg::T_TX: if (sclFall) begin
                    bitCnt_d = bitCnt_q + 3'h1;
                    sh_d = {sh_q[6:0], 1'b0};
                    oe_d = ~sh_q[6];
                    if (bitCnt_q == 3'h7) begin
                        oe_d = 1'b0; st_d = two_wire_pkg::T_HACK;
                    end
                end
                two_wire_pkg::T_HACK: if (sclRise) begin
                    // No acknowledge from host ends the read
                    st_d = sdaS2_q ? two_wire_pkg::T_IDLE : two_wire_pkg::T_ACK;
                end
                default: st_d = two_wire_pkg::T_IDLE;
            endcase
        end
    end

    // Target registers; pins pass two flops before any logic
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= two_wire_pkg::T_IDLE; bitCnt_q <= 3'h0; byteNum_q <= 2'h0;
            sh_q <= 8'h00; wrData_q <= 8'h00; index_q <= 16'h0000;
            codeAddr_q <= 16'h0000; devAddr_q <= two_wire_pkg::TGT_WR_ADDR[7:1];
            rdMode_q <= 1'b0; oe_q <= 1'b0; hold_q <= 1'b0; inc_q <= 1'b0;
            wrEn_q <= 1'b0; rdEn_q <= 1'b0; codeEn_q <= 1'b0;
            sclS1_q <= 1'b1; sclS2_q <= 1'b1; sclS3_q <= 1'b1;
            sdaS1_q <= 1'b1; sdaS2_q <= 1'b1; sdaS3_q <= 1'b1;
        end else begin
            st_q <= st_d; bitCnt_q <= bitCnt_d; byteNum_q <= byteNum_d;
            sh_q <= sh_d; wrData_q <= wrData_d; index_q <= index_d;
            codeAddr_q <= codeAddr_d; devAddr_q <= devAddr_d;
            rdMode_q <= rdMode_d; oe_q <= oe_d; hold_q <= hold_d; inc_q <= inc_d;
            wrEn_q <= wrEn_d; rdEn_q <= rdEn_d; codeEn_q <= codeEn_d;
            sclS1_q <= sclSIn; sclS2_q <= sclS1_q; sclS3_q <= sclS2_q;
            sdaS1_q <= sdaSIn; sdaS2_q <= sdaS1_q; sdaS3_q <= sdaS2_q;
        end
    end

    // Initiator on its own pins
    two_wire_initiator u_initiator (
        .ref_clk(ref_clk), .reset_n(reset_n), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .cmdRead(cmdRead), .cmdRestart(cmdRestart), .cmdDev(cmdDev),
        .cmdIndex(cmdIndex), .cmdLen(cmdLen), .cmdData(cmdData),
        .donePulse(donePulse), .ackErr(ackErr), .rdData(rdData),
        .sclMIn(sclMIn), .sclMOut(sclMOut), .sclMOe(sclMOe),
        .sdaMIn(sdaMIn), .sdaMOut(sdaMOut), .sdaMOe(sdaMOe)
    );

    chk_idle_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == two_wire_pkg::T_IDLE |-> !sdaSOe)
        else $error("target drives data while idle");
    chk_start_restart: assert property (@(posedge ref_clk) disable iff (!reset_n)
        startDet && !stopDet |=> st_q == two_wire_pkg::T_RX && bitCnt_q == 3'h0)
        else $error("start not followed by address reception");
    chk_ack_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == two_wire_pkg::T_DEC && sclFall && byteNum_q != 2'h0 && !startDet && !stopDet
        |=> sdaSOe)
        else $error("target did not acknowledge a word");
    chk_addr_match: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == two_wire_pkg::T_DEC && sclFall && byteNum_q == 2'h0 && !startDet && !stopDet
        && sh_q[7:1] != devAddr_q |=> st_q == two_wire_pkg::T_IDLE && !sdaSOe)
        else $error("target answered a foreign address");
    chk_index_step: assert property (@(posedge ref_clk) disable iff (!reset_n)
        regWrEn ##1 !startDet |-> index_q == $past(index_q) + 16'h0001)
        else $error("index did not step after a byte");
    chk_hold_during: assert property (@(posedge ref_clk) disable iff (!reset_n)
        codeWrEn |-> mcuHoldReset)
        else $error("code write while controller runs");
    chk_addr_reg: assert property (@(posedge ref_clk) disable iff (!reset_n)
        mcuWrEn && mcuAddr == two_wire_pkg::DEV_ADDR_REG
        |=> {devAddr_q, 1'b0} == ($past(mcuWrData) & 8'hfe))
        else $error("address register write lost");
    chk_sys_only: assert property (@(posedge ref_clk) disable iff (!reset_n)
        regWrEn || regRdEn |-> regAddr[15:8] == two_wire_pkg::SYS_PAGE)
        else $error("access outside system registers");
endmodule

// File: src/two_wire_pkg.sv
// Shared constants of the two-wire target and initiator channels
package two_wire_pkg;
    // Target bus address bytes after reset
    localparam logic [7:0] TGT_WR_ADDR = 8'h76;
    localparam logic [7:0] TGT_RD_ADDR = 8'h77;
    // System register offsets seen by the target channel
    localparam logic [15:0] DEV_ADDR_REG = 16'h4006;
    localparam logic [15:0] CODE_ADDR_HI_REG = 16'h4024;
    localparam logic [15:0] CODE_ADDR_LO_REG = 16'h4025;
    localparam logic [15:0] CODE_DATA_REG = 16'h4026;
    localparam logic [7:0] SYS_PAGE = 8'h40;
    // Transfer limits of the initiator
    localparam logic [2:0] MAX_WR_BYTES = 3'h5;
    localparam logic [2:0] MAX_RD_BYTES = 3'h2;
    // Initiator bus clock timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam logic [8:0] QTR_LAST = 9'(SCL_QUARTER_CYC - 1);
    // Target channel states
    typedef enum logic [5:0] {
        T_IDLE = 6'h01, T_RX = 6'h02, T_DEC = 6'h04,
        T_ACK = 6'h08, T_TX = 6'h10, T_HACK = 6'h20
    } tgt_state_t;
    // Initiator channel states
    typedef enum logic [3:0] {
        M_IDLE = 4'h1, M_START = 4'h2, M_BIT = 4'h4, M_STOP = 4'h8
    } ini_state_t;
endpackage

// File: src/two_wire_initiator.sv
// Initiator channel: writes up to five bytes, reads up to two
`timescale 1ns/10ps
module two_wire_initiator (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic cmdRead,
    input wire logic cmdRestart,
    input wire logic [6:0] cmdDev,
    input wire logic [7:0] cmdIndex,
    input wire logic [2:0] cmdLen,
    input wire logic [39:0] cmdData,
    output logic donePulse,
    output logic ackErr,
    output logic [15:0] rdData,
    input wire logic sclMIn,
    output logic sclMOut,
    output logic sclMOe,
    input wire logic sdaMIn,
    output logic sdaMOut,
    output logic sdaMOe
);
    two_wire_pkg::ini_state_t st_q, st_d;
    logic [8:0] qCnt_q, qCnt_d;
    logic [1:0] ph_q, ph_d;
    logic [3:0] bit_q, bit_d;
    logic [2:0] byte_q, byte_d, len_q, len_d;
    logic [6:0] dev_q, dev_d;
    logic [7:0] idx_q, idx_d, sh_q, sh_d;
    logic [39:0] dat_q, dat_d;
    logic [15:0] rd_q, rd_d;
    logic isRd_q, isRd_d, rst_q, rst_d, part2_q, part2_d, pend_q, pend_d;
    logic scl_q, scl_d, sda_q, sda_d, err_q, err_d, done_q, done_d, nack_q, nack_d;
    logic sclS1_q, sclS2_q, sdaS1_q, sdaS2_q;
    logic tick, recv, last;

    // Byte to send for a given position of the transfer
    function automatic logic [7:0] txByte(input logic [2:0] n, input logic p2,
            input logic [6:0] dv, input logic [7:0] ix, input logic [39:0] dt);
        if (p2 || n == 3'h0) begin
            txByte = {dv, p2};
        end else if (n == 3'h1) begin
            txByte = ix;
        end else begin
            txByte = dt[8*(n-3'h2) +: 8];
        end
    endfunction

    assign tick = (qCnt_q == two_wire_pkg::QTR_LAST);
    assign recv = part2_q && byte_q != 3'h0;
    assign last = part2_q ? (byte_q == len_q) : (isRd_q ? byte_q == 3'h1 : byte_q == len_q + 3'h1);
    // Open drain: drive only low, separate pins from the target
    assign sclMOut = 1'b0;
    assign sdaMOut = 1'b0;
    assign sclMOe = ~scl_q;
    assign sdaMOe = ~sda_q;
    assign cmdReady = (st_q == two_wire_pkg::M_IDLE);
    assign donePulse = done_q;
    assign ackErr = err_q;
    assign rdData = rd_q;

    // Bit sequencer, quarter-period phases
    always_comb begin
        st_d = st_q; qCnt_d = tick ? 9'h0 : qCnt_q + 9'h1; ph_d = ph_q;
        bit_d = bit_q; byte_d = byte_q; len_d = len_q; dev_d = dev_q; idx_d = idx_q;
        sh_d = sh_q; dat_d = dat_q; rd_d = rd_q; isRd_d = isRd_q; rst_d = rst_q;
        part2_d = part2_q; pend_d = pend_q; scl_d = scl_q; sda_d = sda_q;
        err_d = err_q; done_d = 1'b0; nack_d = nack_q;
        case (st_q)
            two_wire_pkg::M_IDLE: begin
                qCnt_d = 9'h0; ph_d = 2'h0; scl_d = 1'b1; sda_d = 1'b1;
                if (cmdValid) begin
                    // Clamp burst to the channel limits
                    if (cmdRead) begin
                        len_d = (cmdLen > two_wire_pkg::MAX_RD_BYTES) ?
                            two_wire_pkg::MAX_RD_BYTES : cmdLen;
                    end else begin
                        len_d = (cmdLen > two_wire_pkg::MAX_WR_BYTES) ?
                            two_wire_pkg::MAX_WR_BYTES : cmdLen;
                    end
                    if (cmdLen == 3'h0) len_d = 3'h1;
                    dev_d = cmdDev; idx_d = cmdIndex; dat_d = cmdData;
                    isRd_d = cmdRead; rst_d = cmdRestart; part2_d = 1'b0;
                    pend_d = 1'b0; err_d = 1'b0; nack_d = 1'b0;
                    st_d = two_wire_pkg::M_START;
                end
            end
            two_wire_pkg::M_START: if (tick) begin
                // Data falls while the clock is high
                ph_d = ph_q + 2'h1;
                case (ph_q)
                    2'h0: sda_d = 1'b1;
                    2'h1: scl_d = 1'b1;
                    2'h2: sda_d = 1'b0;
                    default: begin
                        scl_d = 1'b0; ph_d = 2'h0; bit_d = 4'h0; byte_d = 3'h0;
                        sh_d = txByte(3'h0, part2_q, dev_q, idx_q, dat_q);
                        st_d = two_wire_pkg::M_BIT;
                    end
                endcase
            end
            two_wire_pkg::M_BIT: begin
                // Stretched clock holds the high phase
                if (ph_q == 2'h2 && !sclS2_q) qCnt_d = 9'h0;
                if (tick) begin
                    ph_d = ph_q + 2'h1;
                    case (ph_q)
                        2'h0: sda_d = (bit_q == 4'h8) ? (recv ? last : 1'b1) :
                            (recv ? 1'b1 : sh_q[7]);
                        2'h1: scl_d = 1'b1;
                        2'h2: begin
                            if (bit_q != 4'h8) sh_d = {sh_q[6:0], sdaS2_q};
                            else if (!recv && sdaS2_q) nack_d = 1'b1;
                        end
                        default: begin
                            scl_d = 1'b0; bit_d = bit_q + 4'h1;
                            if (bit_q == 4'h8) begin
                                bit_d = 4'h0;
                                if (recv) rd_d = {rd_q[7:0], sh_q};
                                if (nack_q) begin
                                    err_d = 1'b1; pend_d = 1'b0; st_d = two_wire_pkg::M_STOP;
                                end else if (last && isRd_q && !part2_q) begin
                                    // Dummy write done: restart or stop first
                                    part2_d = 1'b1;
                                    pend_d = ~rst_q;
                                    st_d = rst_q ? two_wire_pkg::M_START : two_wire_pkg::M_STOP;
                                end else if (last) begin
                                    st_d = two_wire_pkg::M_STOP;
                                end else begin
                                    byte_d = byte_q + 3'h1;
                                    sh_d = txByte(byte_q + 3'h1, part2_q, dev_q, idx_q, dat_q);
                                end
                            end
                        end
                    endcase
                end
            end
            two_wire_pkg::M_STOP: if (tick) begin
                // Data rises while the clock is high
                ph_d = ph_q + 2'h1;
                case (ph_q)
                    2'h0: sda_d = 1'b0;
                    2'h1: scl_d = 1'b1;
                    2'h2: sda_d = 1'b1;
                    default: begin
                        ph_d = 2'h0;
                        st_d = pend_q ? two_wire_pkg::M_START : two_wire_pkg::M_IDLE;
                        done_d = ~pend_q; pend_d = 1'b0;
                    end
                endcase
            end
            default: st_d = two_wire_pkg::M_IDLE;
        endcase
    end

    // Registers, pins synchronised by two flops
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= two_wire_pkg::M_IDLE; qCnt_q <= 9'h0; ph_q <= 2'h0; bit_q <= 4'h0;
            byte_q <= 3'h0; len_q <= 3'h1; dev_q <= 7'h00; idx_q <= 8'h00;
            sh_q <= 8'h00; dat_q <= 40'h0; rd_q <= 16'h0000; isRd_q <= 1'b0;
            rst_q <= 1'b0; part2_q <= 1'b0; pend_q <= 1'b0; scl_q <= 1'b1;
            sda_q <= 1'b1; err_q <= 1'b0; done_q <= 1'b0; nack_q <= 1'b0;
            sclS1_q <= 1'b1; sclS2_q <= 1'b1; sdaS1_q <= 1'b1; sdaS2_q <= 1'b1;
        end else begin
            st_q <= st_d; qCnt_q <= qCnt_d; ph_q <= ph_d; bit_q <= bit_d;
            byte_q <= byte_d; len_q <= len_d; dev_q <= dev_d; idx_q <= idx_d;
            sh_q <= sh_d; dat_q <= dat_d; rd_q <= rd_d; isRd_q <= isRd_d;
            rst_q <= rst_d; part2_q <= part2_d; pend_q <= pend_d; scl_q <= scl_d;
            sda_q <= sda_d; err_q <= err_d; done_q <= done_d; nack_q <= nack_d;
            sclS1_q <= sclMIn; sclS2_q <= sclS1_q; sdaS1_q <= sdaMIn; sdaS2_q <= sdaS1_q;
        end
    end

    chk_idle_lines_high: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == two_wire_pkg::M_IDLE |-> !sclMOe && !sdaMOe)
        else $error("initiator drives a line while idle");
    chk_write_burst_max: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == two_wire_pkg::M_BIT && !isRd_q |-> byte_q <= 3'h6)
        else $error("initiator write exceeds five data bytes");
    chk_read_burst_max: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == two_wire_pkg::M_BIT && part2_q |-> byte_q <= 3'h2)
        else $error("initiator read exceeds two bytes");
endmodule

// File: verif/two_wire_host.sv
// Host model driving the target channel clock and data lines
`timescale 1ns/10ps
module two_wire_host (
    input wire logic ref_clk,
    input wire logic sdaLine,
    output logic scl,
    output logic sda
);
    // Idle: both lines released high
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Data falls while clock high
    task automatic startC;
        sda <= 1'b1;
        scl <= 1'b1;
        w(10);
        sda <= 1'b0;
        w(10);
        scl <= 1'b0;
    endtask
    // Data rises while clock high, then bus left idle
    task automatic stopC;
        w(5);
        sda <= 1'b0;
        w(5);
        scl <= 1'b1;
        w(10);
        sda <= 1'b1;
        w(10);
    endtask
    // Nine bits, MSB first, 80 ns clock; data moves after the fall has cleared the syncs
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            w(2);
            sda <= tx[i];
            w(3);
            scl <= 1'b1;
            w(3);
            #1 rx[i] = sdaLine;
            w(2);
            scl <= 1'b0;
        end
    endtask
endmodule

// File: verif/tb_top.sv
// Testbench of the two-wire port
`timescale 1ns/10ps
module tb_top;
    logic ref_clk, reset_n, sclS, sdaH, sdaLine, mcuWrEn, cmdValid, sdaSOe, sdaMOe, sclMOe;
    logic regWrEn, codeWrEn, mcuHoldReset, donePulse, ackErr, cmdReady, cmdRd, sdaM;
    logic pOn = 1'b0, ackOn = 1'b0, sclMP = 1'b1, sdaMP = 1'b1;
    logic [15:0] regAddr, codeWrAddr, mcuAddr, lastAddr, cAddr, rdData;
    logic [7:0] regWrData, codeWrData, mcuWrData, lastData, cData;
    logic [6:0] tgtDevAddr, cmdDev;
    logic [8:0] rx;
    int mismatches, checks, wrCnt, cCnt, nRise;
    // Open-drain wire with pull-up
    assign sdaLine = sdaH & ~sdaSOe;
    two_wire_host i_host (.ref_clk(ref_clk), .sdaLine(sdaLine), .scl(sclS), .sda(sdaH));
    two_wire_port i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .sclSIn(sclS),
        .sdaSIn(sdaLine), .sdaSOut(), .sdaSOe(sdaSOe), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(), .regRdData(regAddr[7:0] ^ 8'h5a),
        .mcuWrEn(mcuWrEn), .mcuAddr(mcuAddr), .mcuWrData(mcuWrData), .tgtDevAddr(tgtDevAddr),
        .codeWrEn(codeWrEn), .codeWrAddr(codeWrAddr), .codeWrData(codeWrData),
        .mcuHoldReset(mcuHoldReset), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRd),
        .cmdRestart(1'b1), .cmdDev(cmdDev), .cmdIndex(8'h10), .cmdLen(3'h2),
        .cmdData(40'h00000000c3), .donePulse(donePulse), .ackErr(ackErr), .rdData(rdData),
        .sclMIn(~sclMOe), .sclMOut(), .sclMOe(sclMOe), .sdaMIn(sdaM), .sdaMOut(),
        .sdaMOe(sdaMOe));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Far-end peripheral: when enabled, acks the ninth clock of each byte, else pulled up
    assign sdaM = ~sdaMOe & ~(ackOn & pOn);
    always @(posedge ref_clk) begin
        sclMP <= ~sclMOe;
        sdaMP <= sdaM;
        if (!sclMOe && sclMP && sdaMP && !sdaM) begin
            nRise <= 0;
            ackOn <= 1'b0;
        end else if (!sclMOe && !sclMP) begin
            nRise <= nRise + 1;
        end else if (sclMOe && sclMP) begin
            ackOn <= (nRise % 9 == 8);
        end
    end
    // Register and code-memory strobes captured as they happen
    always @(posedge ref_clk) begin
        if (regWrEn === 1'b1) begin
            wrCnt++;
            lastAddr = regAddr;
            lastData = regWrData;
        end
        if (codeWrEn === 1'b1) begin
            cCnt++;
            cAddr = codeWrAddr;
            cData = codeWrData;
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic sb(input logic [7:0] b, input logic a);
        i_host.xfer({b, 1'b1}, rx);
        chk(16'(rx[0]), 16'(a));
    endtask
    // Send n bytes, first byte in the top used byte
    task automatic sbs(input logic [47:0] s, input int n, input logic a);
        for (int i = n - 1; i >= 0; i--) sb(s[8*i +: 8], a);
    endtask
    // One initiator command, bounded wait for its end
    task automatic ini(input logic rd, input logic ack);
        cmdRd <= rd;
        pOn <= ack;
        cmdValid <= 1'b1;
        @(posedge ref_clk);
        cmdValid <= 1'b0;
        for (int n = 0; n <= 64000; n++) begin
            @(posedge ref_clk);
            if (donePulse === 1'b1) break;
            if (n == 64000) chk(16'h0000, 16'h0001);
        end
        @(posedge ref_clk);
        chk(16'(ackErr), 16'(!ack));
        chk(16'(cmdReady), 16'h0001);
    endtask
    task automatic mw(input logic [7:0] d);
        mcuWrEn <= 1'b1;
        mcuAddr <= two_wire_pkg::DEV_ADDR_REG;
        mcuWrData <= d;
        @(posedge ref_clk);
        mcuWrEn <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    initial begin
        reset_n = 1'b0;
        {mcuWrEn, cmdValid, cmdRd, mcuAddr, mcuWrData, wrCnt, cCnt} = '0;
        cmdDev = 7'h22;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // Write two data bytes; index steps once per byte
        i_host.startC();
        sbs(48'h764010a1a2, 5, 1'b0);
        i_host.stopC();
        chk(lastAddr, 16'h4011);
        chk(16'(lastData), 16'h00a2);
        chk(16'(wrCnt), 16'd2);
        $display("write test done");
        // Foreign address gets no ack and no write
        i_host.startC();
        sb(8'h50, 1'b1);
        sb(8'h40, 1'b1);
        i_host.stopC();
        chk(16'(wrCnt), 16'd2);
        $display("mismatch test done");
        // Dummy write, then four bytes read from successive indexes
        i_host.startC();
        sbs(48'h764010, 3, 1'b0);
        i_host.stopC();
        i_host.startC();
        sb(8'h77, 1'b0);
        for (int k = 0; k < 4; k++) begin
            i_host.xfer({8'hff, k == 3}, rx);
            chk(16'(rx[8:1]), 16'((8'h10 + 8'(k)) ^ 8'h5a));
        end
        i_host.stopC();
        $display("read test done");
        // Controller moves the target address
        mw(8'h60);
        chk(16'(tgtDevAddr), 16'h0030);
        i_host.startC();
        sb(8'h76, 1'b1);
        i_host.stopC();
        i_host.startC();
        sb(8'h60, 1'b0);
        i_host.stopC();
        mw(8'h76);
        $display("address test done");
        // Code download with controller held in reset
        i_host.startC();
        sbs(48'h7640241234ab, 6, 1'b0);
        chk(16'(mcuHoldReset), 16'h0001);
        i_host.stopC();
        chk(cAddr, 16'h1234);
        chk(16'(cData), 16'h00ab);
        chk(16'(cCnt), 16'd1);
        chk(16'(mcuHoldReset), 16'h0000);
        $display("code test done");
        // Initiator write nobody acks, then a two-byte read with restart of pulled-up data
        ini(1'b0, 1'b0);
        chk(16'(sdaSOe), 16'h0000);
        ini(1'b1, 1'b1);
        chk(rdData, 16'hffff);
        $display("initiator test done");
        stop_test();
    end
endmodule
